// >>> common/conversion_start_bit_pkg.sv
// Package of constants and carrier types for the select-mode converter sequencer.
package conversion_start_bit_pkg;

  // ==========================================================================
  // Widths and channel counts
  // ==========================================================================
  localparam int CHAN_W = 3;
  localparam int RES_W = 10;
  localparam int NUM_CHAN_FULL = 8;
  localparam int NUM_CHAN_MID = 6;
  localparam int NUM_CHAN_SMALL = 4;
  localparam int MODE_W = 8;

  // ==========================================================================
  // Field positions and reset values
  // ==========================================================================
  localparam int START_BIT_POS = 7;
  localparam logic [MODE_W-1:0] MODE_RESET = 8'h00;
  localparam logic [CHAN_W-1:0] CHAN_RESET = 3'h0;
  localparam logic [RES_W-1:0] RESULT_RESET = 10'h000;

  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int CLK_PERIOD_NS = 10;
  localparam int CONV_TIME_NS = 1000;
  localparam int CONV_CYCLES_I = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 8;
  localparam logic [CNT_W-1:0] CONV_CYCLES = CNT_W'(CONV_CYCLES_I);

  // ==========================================================================
  // Types
  // ==========================================================================
  typedef enum logic [1:0] {
    CONVERSION_START_BIT_IDLE = 2'b01,
    CONVERSION_START_BIT_CONV = 2'b10
  } conversion_start_bit_state_e;

  typedef struct packed {
    logic wr;
    logic [MODE_W-1:0] data;
  } conversion_start_bit_mode_wr_s;

  typedef struct packed {
    logic wr;
    logic [CHAN_W-1:0] data;
  } conversion_start_bit_chan_wr_s;

endpackage

// >>> dv/conversion_start_bit_analog_model.sv
// Analog front-end model: eight sample words that move only on a load.
`timescale 1ns/1ns
module conversion_start_bit_analog_model (
  // Clock
  input wire logic clk,
  // Load side
  input wire logic load,
  input wire logic [conversion_start_bit_pkg::NUM_CHAN_FULL*conversion_start_bit_pkg::RES_W-1:0] words,
  // Input pins
  output logic [conversion_start_bit_pkg::NUM_CHAN_FULL*conversion_start_bit_pkg::RES_W-1:0] analog_in
);
  // Words only change when loaded, so the sample instant inside a conversion never matters.
  always_ff @(posedge clk) begin
    if (load) begin
      analog_in <= words;
    end
  end
endmodule

// >>> dv/conversion_start_bit_sequencer_bench.sv
// Self-checking bench for the converter sequencer against a cycle model.
`timescale 1ns/1ns
module conversion_start_bit_sequencer_bench;
  localparam int W = conversion_start_bit_pkg::NUM_CHAN_FULL * conversion_start_bit_pkg::RES_W;
  logic clk;
  logic resetn;
  conversion_start_bit_pkg::conversion_start_bit_mode_wr_s mode_wr;
  conversion_start_bit_pkg::conversion_start_bit_chan_wr_s chan_wr;
  logic load;
  logic [W-1:0] words;
  logic [W-1:0] analog_in;
  logic [7:0] mode_reg;
  logic [2:0] chan_reg;
  logic [9:0] result;
  logic busy;
  logic irq;
  int fails, checked, m_cnt, m_busy, m_chan, m_mode, m_res, m_irq;

  conversion_start_bit_sequencer i_conversion_start_bit_sequencer (.clk(clk), .resetn(resetn), .mode_wr(mode_wr),
    .chan_wr(chan_wr), .analog_in(analog_in), .converter_mode_reg(mode_reg),
    .channel_select_reg(chan_reg), .conversion_result_reg(result), .busy_ff(busy),
    .conversion_done_irq(irq));
  conversion_start_bit_analog_model i_conversion_start_bit_analog_model (.clk(clk), .load(load), .words(words),
    .analog_in(analog_in));

  // ====
  // Reference model
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      m_cnt = 0;
      m_busy = 0;
      m_chan = 0;
      m_mode = 0;
      m_res = 0;
      m_irq = 0;
    end else begin
      m_irq = 0;
      if (m_busy != 0 && !(mode_wr.wr && !mode_wr.data[7])) begin
        m_cnt++;
        if (chan_wr.wr) begin
          m_cnt = -1;
        end else if (m_cnt == conversion_start_bit_pkg::CONV_CYCLES_I - 1) begin
          // The last step finishes here; the next conversion's first step is the next edge.
          m_irq = 1;
          m_cnt = -1;
          m_res = analog_in[m_chan*10 +: 10];
        end
      end
      if (mode_wr.wr) begin
        m_mode = mode_wr.data;
        if (mode_wr.data[7] && m_busy == 0) begin
          m_cnt = -1;
        end
        m_busy = mode_wr.data[7];
      end
      if (chan_wr.wr) begin
        m_chan = chan_wr.data;
      end
    end
  end

  task automatic check(input logic [9:0] got, input int exp, input string what);
    checked++;
    if (got !== 10'(exp)) begin
      fails++;
      $display("mismatch at %0t: %s got %0h expected %0h", $time, what, got, exp);
    end
  endtask

  always @(negedge clk) begin
    if (resetn) begin
      check(10'(irq), m_irq, "done pulse");
      check(result, m_res, "result");
      check(10'(busy), m_busy, "busy");
      check(10'(chan_reg), m_chan, "channel");
      check(10'(mode_reg), m_mode, "mode");
    end
  end

  // ====
  // Drivers and closing
  task automatic put_mode(input logic [7:0] v);
    @(posedge clk);
    mode_wr <= {1'b1, v};
    @(posedge clk);
    mode_wr.wr <= 1'b0;
  endtask

  task automatic put_chan(input logic [2:0] c);
    @(posedge clk);
    chan_wr <= {1'b1, c};
    @(posedge clk);
    chan_wr.wr <= 1'b0;
  endtask

  task automatic new_words;
    @(posedge clk);
    load <= 1'b1;
    words <= W'({$urandom, $urandom, $urandom});
    @(posedge clk);
    load <= 1'b0;
  endtask

  task automatic finish_test;
    $display("checks %0d, mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // The whole sequence needs about 4400 cycles (at most about 13000); the limit leaves ample margin.
  initial begin
    repeat (40000) @(posedge clk);
    fails++;
    finish_test();
  end

  // ====
  // Tests
  initial begin
    resetn = 1'b0;
    mode_wr = '0;
    chan_wr = '0;
    load = 1'b0;
    words = '0;
    void'($urandom(63363));
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    new_words();
    repeat (150) @(posedge clk);
    $display("test idle after reset done");
    for (int c = 0; c < conversion_start_bit_pkg::NUM_CHAN_FULL; c++) begin
      put_chan(3'(c));
      put_mode(8'h80);
      repeat (250) @(posedge clk);
      put_mode(8'h00);
      new_words();
    end
    $display("test all channels done");
    put_mode(8'h80);
    repeat (60) @(posedge clk);
    put_chan(3'h5);
    repeat (99) @(posedge clk);
    put_chan(3'h2);
    repeat (150) @(posedge clk);
    put_mode(8'h00);
    put_mode(8'h80);
    repeat (120) @(posedge clk);
    resetn <= 1'b0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    repeat (150) @(posedge clk);
    $display("test restart, stop and reset done");
    for (int i = 0; i < 40; i++) begin
      case ($urandom_range(3))
        0: put_chan(3'($urandom));
        1: put_mode(8'($urandom) | 8'h80);
        2: begin
          put_mode(8'($urandom) & 8'h7F);
          new_words();
        end
        default: repeat ($urandom_range(250)) @(posedge clk);
      endcase
    end
    repeat (250) @(posedge clk);
    $display("test random traffic done");
    finish_test();
  end
endmodule

// >>> logic/conversion_start_bit_result_mem.sv
// Result holding register for the converter sequencer.
`timescale 1ns/1ns
module conversion_start_bit_result_mem (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Write side
  input wire logic wr_en,
  input wire logic [conversion_start_bit_pkg::RES_W-1:0] wr_data,
  // Read side
  output logic [conversion_start_bit_pkg::RES_W-1:0] rd_data
);

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rd_data <= conversion_start_bit_pkg::RESULT_RESET;
    end else if (wr_en) begin
      rd_data <= wr_data;
    end
  end

endmodule

// >>> logic/conversion_start_bit_sequencer.sv
// Select-mode converter sequencer: channel select, start control, result and done pulse.
// Contract
// - One analog input is converted at a time, the one named by channel_select_reg.
// - Eight channels are offered here; smaller variants simply leave the upper ones unused.
// - Writing 1 to bit 7 of converter_mode_reg starts conversion of the selected input.
// - Each finished conversion stores its value in conversion_result_reg and pulses the done irq.
// - After each conversion the next one on the selected channel starts at once while started.
// - A channel select write during conversion abandons it and restarts from the first step.
// - Writing 0 to the start bit halts conversion at once and keeps the last result.
`timescale 1ns/1ns
module conversion_start_bit_sequencer (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // CPU-side register writes
  input wire conversion_start_bit_pkg::conversion_start_bit_mode_wr_s mode_wr,
  input wire conversion_start_bit_pkg::conversion_start_bit_chan_wr_s chan_wr,
  // Analog front end: one sample word per input
  input wire logic [conversion_start_bit_pkg::NUM_CHAN_FULL*conversion_start_bit_pkg::RES_W-1:0] analog_in,
  // Register views
  output logic [conversion_start_bit_pkg::MODE_W-1:0] converter_mode_reg,
  output logic [conversion_start_bit_pkg::CHAN_W-1:0] channel_select_reg,
  output logic [conversion_start_bit_pkg::RES_W-1:0] conversion_result_reg,
  // Status
  output logic busy_ff,
  output logic conversion_done_irq
);

  // ==========================================================================
  // Registers and next values
  // ==========================================================================
  conversion_start_bit_pkg::conversion_start_bit_state_e state_ff;
  conversion_start_bit_pkg::conversion_start_bit_state_e nxt_state;
  logic [conversion_start_bit_pkg::MODE_W-1:0] mode_ff;
  logic [conversion_start_bit_pkg::CHAN_W-1:0] chan_ff;
  logic [conversion_start_bit_pkg::CNT_W-1:0] cnt_ff;
  logic [conversion_start_bit_pkg::CNT_W-1:0] nxt_cnt;
  logic [conversion_start_bit_pkg::RES_W-1:0] sample_ff;
  logic done_ff;
  logic start_bit;
  logic restart;
  logic finish;
  logic [conversion_start_bit_pkg::RES_W-1:0] sel_sample;

  function automatic logic [conversion_start_bit_pkg::RES_W-1:0] pick_chan(
    input logic [conversion_start_bit_pkg::NUM_CHAN_FULL*conversion_start_bit_pkg::RES_W-1:0] bus,
    input logic [conversion_start_bit_pkg::CHAN_W-1:0] ch
  );
    pick_chan = bus[ch*conversion_start_bit_pkg::RES_W +: conversion_start_bit_pkg::RES_W];
  endfunction

  // ==========================================================================
  // Decode
  // ==========================================================================
  // The new mode value takes effect in the same cycle it is written so a stop
  // never lets one more conversion finish.
  assign start_bit = mode_wr.wr ? mode_wr.data[conversion_start_bit_pkg::START_BIT_POS]
                                : mode_ff[conversion_start_bit_pkg::START_BIT_POS];
  assign restart = chan_wr.wr && state_ff == conversion_start_bit_pkg::CONVERSION_START_BIT_CONV;
  assign finish = state_ff == conversion_start_bit_pkg::CONVERSION_START_BIT_CONV && start_bit && !restart
                  && cnt_ff == conversion_start_bit_pkg::CONV_CYCLES - 8'h01;
  assign sel_sample = pick_chan(analog_in, chan_ff);

  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    case (state_ff)
      conversion_start_bit_pkg::CONVERSION_START_BIT_IDLE: begin
        nxt_cnt = 8'h00;
        if (start_bit) begin
          nxt_state = conversion_start_bit_pkg::CONVERSION_START_BIT_CONV;
        end
      end
      conversion_start_bit_pkg::CONVERSION_START_BIT_CONV: begin
        if (!start_bit) begin
          nxt_state = conversion_start_bit_pkg::CONVERSION_START_BIT_IDLE;
          nxt_cnt = 8'h00;
        end else if (restart || finish) begin
          nxt_cnt = 8'h00;
        end else begin
          nxt_cnt = cnt_ff + 8'h01;
        end
      end
      default: begin
        nxt_state = conversion_start_bit_pkg::CONVERSION_START_BIT_IDLE;
        nxt_cnt = 8'h00;
      end
    endcase
  end

  // ==========================================================================
  // State
  // ==========================================================================
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_ff <= conversion_start_bit_pkg::CONVERSION_START_BIT_IDLE;
      cnt_ff <= 8'h00;
      done_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      done_ff <= finish;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      mode_ff <= conversion_start_bit_pkg::MODE_RESET;
      chan_ff <= conversion_start_bit_pkg::CHAN_RESET;
    end else begin
      if (mode_wr.wr) begin
        mode_ff <= mode_wr.data;
      end
      if (chan_wr.wr) begin
        chan_ff <= chan_wr.data;
      end
    end
  end

  // The sample is taken at the first step so a channel change mid-conversion
  // is reflected only through the restart.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sample_ff <= conversion_start_bit_pkg::RESULT_RESET;
    end else if (state_ff == conversion_start_bit_pkg::CONVERSION_START_BIT_CONV && cnt_ff == 8'h00) begin
      sample_ff <= sel_sample;
    end
  end

  conversion_start_bit_result_mem i_conversion_start_bit_result_mem (
    .clk(clk),
    .resetn(resetn),
    .wr_en(finish),
    .wr_data(sample_ff),
    .rd_data(conversion_result_reg)
  );

  // ==========================================================================
  // Outputs
  // ==========================================================================
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      busy_ff <= 1'b0;
    end else begin
      busy_ff <= nxt_state == conversion_start_bit_pkg::CONVERSION_START_BIT_CONV;
    end
  end

  assign converter_mode_reg = mode_ff;
  assign channel_select_reg = chan_ff;
  assign conversion_done_irq = done_ff;

  // ==========================================================================
  // Checks
  // ==========================================================================
  a_done_stores: assert property (@(posedge clk) disable iff (!resetn)
    finish |=> conversion_done_irq && conversion_result_reg == $past(sample_ff))
    else $error("result not stored with done pulse");

  a_stop_halts: assert property (@(posedge clk) disable iff (!resetn)
    (mode_wr.wr && !mode_wr.data[conversion_start_bit_pkg::START_BIT_POS])
      |=> state_ff == conversion_start_bit_pkg::CONVERSION_START_BIT_IDLE && !conversion_done_irq)
    else $error("stop did not halt conversion");

  a_stop_keeps: assert property (@(posedge clk) disable iff (!resetn)
    state_ff == conversion_start_bit_pkg::CONVERSION_START_BIT_IDLE |=> $stable(conversion_result_reg))
    else $error("result changed while stopped");

  a_start_runs: assert property (@(posedge clk) disable iff (!resetn)
    (state_ff == conversion_start_bit_pkg::CONVERSION_START_BIT_IDLE && mode_wr.wr && mode_wr.data[conversion_start_bit_pkg::START_BIT_POS])
      |=> state_ff == conversion_start_bit_pkg::CONVERSION_START_BIT_CONV && cnt_ff == 8'h00)
    else $error("start did not begin conversion");

  a_restart_chan: assert property (@(posedge clk) disable iff (!resetn)
    (restart && start_bit) |=> cnt_ff == 8'h00 && state_ff == conversion_start_bit_pkg::CONVERSION_START_BIT_CONV)
    else $error("channel write did not restart");

  a_continuous: assert property (@(posedge clk) disable iff (!resetn)
    (finish && !mode_wr.wr && !chan_wr.wr) |=> state_ff == conversion_start_bit_pkg::CONVERSION_START_BIT_CONV
      && cnt_ff == 8'h00)
    else $error("next conversion not started");

  a_idle_quiet: assert property (@(posedge clk) disable iff (!resetn)
    !mode_ff[conversion_start_bit_pkg::START_BIT_POS] && !mode_wr.wr |=> !conversion_done_irq)
    else $error("conversion without start bit");

  a_sample_chan: assert property (@(posedge clk) disable iff (!resetn)
    (state_ff == conversion_start_bit_pkg::CONVERSION_START_BIT_CONV && cnt_ff == 8'h00)
      |=> sample_ff == $past(sel_sample))
    else $error("wrong channel sampled");

endmodule
